// *** logic/iocf_pkg.sv ***
// Package for the I/O translation input filter: operation codes, carriers,
// register map and configuration encodings.
// Assumes one clock domain and a single AHB-Lite slave port for software.
package iocf_pkg;

  // Address width of client transactions
  localparam int IOCF_AW = 48;

  // Page that a transfer must not cross
  localparam logic [11:0] IOCF_PAGE_LAST = 12'hfff;

  // Incoming operation codes from the upstream interconnect
  typedef enum logic [3:0] {
    IOCF_OP_READ    = 4'h0,
    IOCF_OP_WRITE   = 4'h1,
    IOCF_OP_ATOMIC  = 4'h2,
    IOCF_OP_VMMSG   = 4'h3,
    IOCF_OP_BARRIER = 4'h4,
    IOCF_OP_CLEAN   = 4'h5,
    IOCF_OP_INV     = 4'h6,
    IOCF_OP_CLNINV  = 4'h7,
    IOCF_OP_PERSIST = 4'h8,
    IOCF_OP_CMONOAD = 4'h9
  } iocf_op_t;

  // Transaction class, fixed before any permission check
  typedef enum logic [1:0] {
    IOCF_CLS_DATA    = 2'h0,
    IOCF_CLS_CMO     = 2'h1,
    IOCF_CLS_NONDATA = 2'h2,
    IOCF_CLS_UNSUP   = 2'h3
  } iocf_cls_t;

  // Stall machine, Gray coded along RUN -> STALLED -> RESUME; RESUME -> RUN flips both bits
  typedef enum logic [1:0] {
    IOCF_ST_RUN     = 2'b00,
    IOCF_ST_STALLED = 2'b01,
    IOCF_ST_RESUME  = 2'b11
  } iocf_st_t;

  // Client request
  typedef struct packed {
    iocf_op_t op;
    logic [IOCF_AW-1:0] addr;
    logic [11:0] len_m1;      // Bytes minus one
    logic instr;              // Instruction/data input
    logic priv;               // Privilege input
    logic sh_valid;           // Shareability supplied
    logic [1:0] sh;
  } iocf_req_t;

  // Per-stream configuration from the stream table entry
  typedef struct packed {
    logic [2:0] cfg;          // Stream configuration field
    logic substream_default_skip_skip;         // Substream default skip active
    logic invalidate_passthrough_enable;                // Invalidate passthrough enable
    logic [1:0] instr_data_override;      // Instr/data override
    logic [1:0] privilege_override;      // Privilege override
    logic access_fault_disable;               // Access fault disable
    logic secure;
  } iocf_ste_t;

  // Permission and descriptor results of the single lookup
  typedef struct packed {
    logic r_priv;
    logic w_priv;
    logic x_priv;
    logic r_user;
    logic w_user;
    logic x_user;
    logic desc_af;            // Descriptor access flag already set
    logic out_ns;             // Output lands in non-secure space
  } iocf_perm_t;

  // Forwarded transaction
  typedef struct packed {
    iocf_op_t op;
    logic [IOCF_AW-1:0] addr;
    logic [1:0] sh;
    logic has_mtype;
  } iocf_out_t;

  // Stream configuration encodings
  localparam logic [2:0] IOCF_CFG_BYPASS = 3'b100;
  localparam logic [2:0] IOCF_CFG_S1 = 3'b101;
  localparam logic [1:0] IOCF_INST_DATA = 2'b10;
  localparam logic [1:0] IOCF_INST_INSTR = 2'b11;
  localparam logic [1:0] IOCF_PRIV_USER = 2'b10;
  localparam logic [1:0] IOCF_PRIV_PRIV = 2'b11;

  // Completion responses
  localparam logic [1:0] IOCF_RESP_OKAY = 2'b00;
  localparam logic [1:0] IOCF_RESP_SLVERR = 2'b10;

  // Register map, byte addresses
  localparam logic [7:0] IOCF_REG_CTRL = 8'h00;
  localparam logic [7:0] IOCF_REG_STAT = 8'h04;
  localparam logic [7:0] IOCF_REG_FLT = 8'h08;

  // Control register fields
  localparam int IOCF_C_BOUND = 0;
  localparam int IOCF_C_ATOM = 1;
  localparam int IOCF_C_DSCMO = 2;
  localparam int IOCF_C_STALL = 3;
  localparam int IOCF_C_HA = 4;
  localparam int IOCF_C_SIF = 5;
  localparam int IOCF_C_GBYP = 6;
  localparam int IOCF_C_DSH = 8;
  localparam logic [9:0] IOCF_CTRL_RST = 10'h007;
endpackage

// *** logic/iocf_filter.sv ***
// Transaction-class filter at the input of an I/O translation unit.
// Assumes the lookup results on PERM belong to the request on REQ in the
// same cycle, and that the AHB-Lite master issues single word transfers.
//
// Behaviour
// RULE1 - One lookup and one decision per transaction
// RULE2 - Page crossing flagged as unsupported when enabled
// RULE3 - Unsupported atomics aborted, unsupported event raised
// RULE4 - Virtual memory messages, barriers end with SLVERR
// RULE5 - Four address-based maintenance classes are recognised
// RULE6 - Maintenance without address silently terminated
// RULE7 - Full bypass forwards maintenance unchanged
// RULE8 - Secure fetch restriction checked, bypass and translated
// RULE9 - No downstream maintenance support: silent termination
// RULE10 - Passthrough enable low turns Invalidate into CleanInvalidate
// RULE11 - Passthrough enable only under applied translation
// RULE12 - Clean classes need read-or-execute, fail like read
// RULE13 - Invalidate needs read-or-execute plus write permission
// RULE14 - Maintenance faults recorded as read accesses
// RULE15 - Maintenance faults stall like reads, retry keeps type
// RULE16 - Hardware access flag update for maintenance
// RULE17 - Maintenance carries no memory type, raw shareability
// RULE18 - Shareability handling in every bypass and translation
// RULE19 - Classify requests before any permission check
//
// The address map and the AHB-Lite slave port were decided locally.
module iocf_filter
  import iocf_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [7:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Client request side
  input wire logic REQ_VALID,
  input wire iocf_req_t REQ,
  input wire iocf_ste_t STREAM_TABLE_ENTRY,
  input wire iocf_perm_t PERM,
  output logic REQ_READY,
  // Stall resolution
  input wire logic RESUME_VALID,
  input wire logic RESUME_RETRY,
  // Downstream and completion
  output logic FWD_VALID,
  output iocf_out_t FWD,
  output logic TERM_VALID,
  output logic [1:0] TERM_RESP,
  output logic UUT_EVENT,
  output logic FAULT_VALID,
  output logic FAULT_READ,
  output logic FAULT_INSTR,
  output logic STALL,
  output logic AF_UPDATE
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Class decode, shared by the decision logic and the checks
  function automatic iocf_cls_t cls_of(input iocf_op_t op);
    case (op)
      IOCF_OP_READ, IOCF_OP_WRITE, IOCF_OP_ATOMIC: cls_of = IOCF_CLS_DATA;
      IOCF_OP_CLEAN, IOCF_OP_INV, IOCF_OP_CLNINV, IOCF_OP_PERSIST: begin
        cls_of = IOCF_CLS_CMO; // [RULE5]
      end
      IOCF_OP_VMMSG, IOCF_OP_BARRIER, IOCF_OP_CMONOAD: cls_of = IOCF_CLS_NONDATA;
      default: cls_of = IOCF_CLS_UNSUP;
    endcase
  endfunction

  // Page crossing test on the low address bits
  function automatic logic crosses(input iocf_req_t r);
    logic [12:0] last;
    last = {1'b0, r.addr[11:0]} + {1'b0, r.len_m1};
    crosses = last > {1'b0, IOCF_PAGE_LAST};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register file over AHB-Lite

  logic [9:0] ctrl_q; // Control bits
  logic [15:0] uut_cnt_q; // Unsupported events seen
  logic [15:0] sil_cnt_q; // Silent terminations seen
  logic [4:0] flt_q; // Last fault: instr, op
  logic wr_pend_q; // Write data phase pending
  logic [7:0] wr_addr_q; // Its address
  logic [31:0] rdata_d;
  logic addr_ph;

  assign addr_ph = HSEL && HREADY && HTRANS[1];

  // Read mux, registered so HRDATA is a flop; unmapped reads zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (HADDR)
      IOCF_REG_CTRL: rdata_d = {22'h00_0000, ctrl_q};
      IOCF_REG_STAT: rdata_d = {sil_cnt_q, uut_cnt_q};
      IOCF_REG_FLT: rdata_d = {27'h000_0000, flt_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Bus front end; zero wait states, always OKAY
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      wr_pend_q <= addr_ph && HWRITE;
      if (addr_ph) begin
        wr_addr_q <= HADDR;
      end
      if (addr_ph && !HWRITE) begin
        HRDATA <= rdata_d;
      end
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // Control register; writes elsewhere are ignored
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ctrl_q <= IOCF_CTRL_RST;
    end else if (wr_pend_q && wr_addr_q == IOCF_REG_CTRL) begin
      ctrl_q <= HWDATA[9:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request selection and stall machine

  iocf_st_t st_q, st_d; // Stall state
  iocf_req_t held_req_q; // Stalled request, kept verbatim
  iocf_ste_t held_ste_q;
  logic eval_valid;
  iocf_req_t ev_req;
  iocf_ste_t ev_ste;

  // A retried request is the held one with its original op
  assign ev_req = (st_q == IOCF_ST_RESUME) ? held_req_q : REQ; // [RULE15]
  assign ev_ste = (st_q == IOCF_ST_RESUME) ? held_ste_q : STREAM_TABLE_ENTRY;
  assign eval_valid = (st_q == IOCF_ST_RESUME) || (st_q == IOCF_ST_RUN && REQ_VALID);

  ////////////////////////////////////////////////////////////////////////
  // Decision

  iocf_cls_t cls;
  logic instr_eff, priv_eff, rx_ok, w_ok, translated, sif_fail;
  logic do_fwd, do_term, do_uut, do_fault, do_stall, do_af, silent;
  logic [1:0] resp;
  iocf_out_t fwd_d;

  // One evaluation per request, every path ends in exactly one outcome
  always_comb begin
    cls = cls_of(ev_req.op); // [RULE19]
    instr_eff = (ev_ste.instr_data_override == IOCF_INST_INSTR) ||
                (ev_ste.instr_data_override != IOCF_INST_DATA && ev_req.instr);
    priv_eff = (ev_ste.privilege_override == IOCF_PRIV_PRIV) ||
               (ev_ste.privilege_override != IOCF_PRIV_USER && ev_req.priv);
    // Read or execute chosen by effective instr/data, at effective level
    rx_ok = instr_eff ? (priv_eff ? PERM.x_priv : PERM.x_user)
                      : (priv_eff ? PERM.r_priv : PERM.r_user); // [RULE12]
    w_ok = priv_eff ? PERM.w_priv : PERM.w_user;
    // Skip of the only stage counts as bypass as well
    translated = !ctrl_q[IOCF_C_GBYP] && ev_ste.cfg != IOCF_CFG_BYPASS &&
                 !(ev_ste.cfg == IOCF_CFG_S1 && ev_ste.substream_default_skip_skip); // [RULE11]
    sif_fail = ev_ste.secure && ctrl_q[IOCF_C_SIF] && instr_eff && PERM.out_ns;
    do_fwd = 1'b0;
    do_term = 1'b0;
    do_uut = 1'b0;
    do_fault = 1'b0;
    do_af = 1'b0;
    silent = 1'b0;
    resp = IOCF_RESP_OKAY;
    fwd_d.op = ev_req.op;
    fwd_d.addr = ev_req.addr;
    // Raw input shareability or the default, in every configuration
    fwd_d.sh = ev_req.sh_valid ? ev_req.sh : ctrl_q[IOCF_C_DSH +: 2]; // [RULE17] [RULE18]
    fwd_d.has_mtype = (cls == IOCF_CLS_DATA);
    if (cls inside {IOCF_CLS_DATA, IOCF_CLS_CMO} && ctrl_q[IOCF_C_BOUND] && crosses(ev_req)) begin
      do_uut = 1'b1; // [RULE2]
    end else if (ev_req.op == IOCF_OP_ATOMIC && !ctrl_q[IOCF_C_ATOM]) begin
      do_uut = 1'b1; // [RULE3]
    end else if (cls == IOCF_CLS_NONDATA || cls == IOCF_CLS_UNSUP) begin
      silent = 1'b1; // [RULE4] [RULE6]
      resp = (ev_req.op == IOCF_OP_CMONOAD) ? IOCF_RESP_OKAY : IOCF_RESP_SLVERR;
    end else if (cls == IOCF_CLS_CMO && !ctrl_q[IOCF_C_DSCMO]) begin
      silent = 1'b1; // [RULE9]
    end else if (sif_fail) begin
      do_fault = 1'b1; // [RULE8]
    end else if (!translated) begin
      do_fwd = 1'b1; // [RULE7]
    end else if (cls == IOCF_CLS_CMO) begin
      if (!rx_ok) begin
        do_fault = 1'b1; // [RULE12] [RULE13]
      end else begin
        do_fwd = 1'b1;
        // Invalidate leaves as such only when enabled and writable
        if (ev_req.op == IOCF_OP_INV && (!ev_ste.invalidate_passthrough_enable || !w_ok)) begin
          fwd_d.op = IOCF_OP_CLNINV; // [RULE10] [RULE13]
        end
        do_af = ctrl_q[IOCF_C_HA] && !PERM.desc_af && !ev_ste.access_fault_disable; // [RULE16]
      end
    end else begin
      do_fault = (ev_req.op == IOCF_OP_READ) ? !rx_ok : !w_ok;
      do_fwd = !do_fault;
    end
    do_stall = do_fault && ctrl_q[IOCF_C_STALL]; // [RULE15]
    if (do_uut || silent || (do_fault && !do_stall)) begin
      do_term = 1'b1;
      if (!silent) begin
        resp = IOCF_RESP_SLVERR;
      end
    end
    if (!eval_valid) begin
      do_fwd = 1'b0;
      do_term = 1'b0;
      do_uut = 1'b0;
      do_fault = 1'b0;
      do_stall = 1'b0;
      do_af = 1'b0;
      silent = 1'b0;
    end
  end

  // Stall state: a terminate from software ends the held request
  always_comb begin
    st_d = st_q;
    case (st_q)
      IOCF_ST_RUN: if (do_stall) st_d = IOCF_ST_STALLED;
      IOCF_ST_STALLED: begin
        if (RESUME_VALID) begin
          st_d = RESUME_RETRY ? IOCF_ST_RESUME : IOCF_ST_RUN;
        end
      end
      IOCF_ST_RESUME: st_d = do_stall ? IOCF_ST_STALLED : IOCF_ST_RUN;
      default: st_d = IOCF_ST_RUN;
    endcase
  end

  // Stall bookkeeping
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      st_q <= IOCF_ST_RUN;
      held_req_q <= '0;
      held_ste_q <= '0;
      REQ_READY <= 1'b1;
    end else begin
      st_q <= st_d;
      if (do_stall) begin
        held_req_q <= ev_req;
        held_ste_q <= ev_ste;
      end
      REQ_READY <= (st_d == IOCF_ST_RUN);
    end
  end

  // Outcome outputs, one registered stage
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      FWD_VALID <= 1'b0;
      FWD <= '0;
      TERM_VALID <= 1'b0;
      TERM_RESP <= IOCF_RESP_OKAY;
      UUT_EVENT <= 1'b0;
      STALL <= 1'b0;
      AF_UPDATE <= 1'b0;
    end else begin
      FWD_VALID <= do_fwd; // [RULE1]
      FWD <= do_fwd ? fwd_d : FWD;
      // A software terminate of a stalled request aborts it
      TERM_VALID <= do_term || (st_q == IOCF_ST_STALLED && RESUME_VALID && !RESUME_RETRY);
      TERM_RESP <= (do_term) ? resp : IOCF_RESP_SLVERR;
      UUT_EVENT <= do_uut; // [RULE3]
      STALL <= do_stall;
      AF_UPDATE <= do_af; // [RULE16]
    end
  end

  // Fault record: maintenance always reported as a read
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      FAULT_VALID <= 1'b0;
      FAULT_READ <= 1'b0;
      FAULT_INSTR <= 1'b0;
      flt_q <= 5'h00;
    end else begin
      FAULT_VALID <= do_fault;
      if (do_fault) begin
        FAULT_READ <= (ev_req.op != IOCF_OP_WRITE); // [RULE14]
        FAULT_INSTR <= instr_eff;
        flt_q <= {instr_eff, ev_req.op};
      end
    end
  end

  // Event counters, saturating so software never sees a wrap
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      uut_cnt_q <= 16'h0000;
      sil_cnt_q <= 16'h0000;
    end else begin
      if (do_uut && uut_cnt_q != 16'hffff) uut_cnt_q <= uut_cnt_q + 16'h0001;
      if (silent && sil_cnt_q != 16'hffff) sil_cnt_q <= sil_cnt_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  sequence s_nondata_in;
    eval_valid && (ev_req.op == IOCF_OP_VMMSG || ev_req.op == IOCF_OP_BARRIER);
  endsequence

  sequence s_slverr_quiet;
    TERM_VALID && TERM_RESP == IOCF_RESP_SLVERR && !FWD_VALID && !UUT_EVENT;
  endsequence

  sequence s_stall_then_retry;
    STALL ##1 (st_q == IOCF_ST_STALLED && RESUME_VALID && RESUME_RETRY);
  endsequence

  property p_one_outcome;
    eval_valid |=> $onehot({FWD_VALID, TERM_VALID, STALL});
  endproperty
  a_one_outcome: assert property (p_one_outcome) else $error("not one outcome"); // [RULE1]

  property p_cross_uut;
    eval_valid && cls inside {IOCF_CLS_DATA, IOCF_CLS_CMO} && crosses(ev_req) &&
      ctrl_q[IOCF_C_BOUND] |=> UUT_EVENT && TERM_VALID && !FWD_VALID;
  endproperty
  a_cross_uut: assert property (p_cross_uut) else $error("page cross not aborted"); // [RULE2]

  property p_atomic_abort;
    eval_valid && ev_req.op == IOCF_OP_ATOMIC && !ctrl_q[IOCF_C_ATOM]
      |=> UUT_EVENT && TERM_RESP == IOCF_RESP_SLVERR;
  endproperty
  a_atomic_abort: assert property (p_atomic_abort) else $error("atomic not aborted"); // [RULE3]

  property p_nondata;
    s_nondata_in |=> s_slverr_quiet;
  endproperty
  a_nondata: assert property (p_nondata) else $error("non-data not ended quietly"); // [RULE4]

  property p_noaddr;
    eval_valid && ev_req.op == IOCF_OP_CMONOAD |=> TERM_VALID && !FWD_VALID && !UUT_EVENT;
  endproperty
  a_noaddr: assert property (p_noaddr) else $error("addressless cmo forwarded"); // [RULE6]

  property p_no_ds_cmo;
    FWD_VALID && !$past(ctrl_q[IOCF_C_DSCMO]) |-> cls_of(FWD.op) != IOCF_CLS_CMO;
  endproperty
  a_no_ds_cmo: assert property (p_no_ds_cmo) else $error("cmo sent downstream"); // [RULE9]

  property p_bypass_keep;
    FWD_VALID && cls_of(FWD.op) == IOCF_CLS_CMO && !$past(translated)
      |-> FWD.op == $past(ev_req.op);
  endproperty
  a_bypass_keep: assert property (p_bypass_keep) else $error("bypass cmo altered"); // [RULE7]

  property p_inv_convert;
    FWD_VALID && $past(ev_req.op) == IOCF_OP_INV && $past(translated) && !$past(ev_ste.invalidate_passthrough_enable)
      |-> FWD.op == IOCF_OP_CLNINV;
  endproperty
  a_inv_convert: assert property (p_inv_convert) else $error("invalidate kept"); // [RULE10]

  property p_cmo_fault_read;
    eval_valid && cls == IOCF_CLS_CMO && do_fault |=> FAULT_VALID && FAULT_READ;
  endproperty
  a_cmo_fault_read: assert property (p_cmo_fault_read) else $error("cmo fault not read"); // [RULE14]

  property p_retry_type;
    s_stall_then_retry |=> ev_req.op == $past(held_req_q.op, 1) && eval_valid;
  endproperty
  a_retry_type: assert property (p_retry_type) else $error("retry changed type"); // [RULE15]

  property p_cmo_no_mtype;
    FWD_VALID && cls_of(FWD.op) == IOCF_CLS_CMO |-> !FWD.has_mtype;
  endproperty
  a_cmo_no_mtype: assert property (p_cmo_no_mtype) else $error("cmo has memory type"); // [RULE17]

endmodule

// *** verif/iocf_client.sv ***
// Client device model for the upstream request port of the filter.
// Assumes a request is taken at an edge where valid and ready are both high.
module iocf_client
  import iocf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic issue,
  input wire iocf_req_t req_in,
  input wire logic ready,
  output logic valid,
  output iocf_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial begin
    valid = 1'b0;
    req = '0;
  end

  // Hold each request until taken; afterwards drive the inverse so that
  // a stale request is never mistaken for a live one
  always @(posedge clk) begin
    if (rst) begin
      valid <= 1'b0;
    end else if (valid && ready) begin
      valid <= 1'b0;
      req <= iocf_req_t'(~req);
    end else if (!valid && issue) begin
      valid <= 1'b1;
      req <= req_in;
    end
  end
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the transaction-class filter.
// Assumes zero-wait AHB-Lite slave and one outcome pulse per request.
module testbench
  import iocf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk, reset, hsel, hwrite, issue, valid, req_ready, resume_valid, resume_retry;
  logic [7:0] haddr;
  logic [1:0] htrans, term_resp;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, v0, v1;
  logic hreadyout, hresp, fwd_valid, term_valid, uut_event, fault_valid;
  logic fault_read, fault_instr, stall, af_update, got_rdy;
  iocf_req_t rq, req;
  iocf_ste_t s;
  iocf_perm_t p;
  iocf_out_t fwd;
  logic [14:0] got; // Outcome flags, then forwarded op, sh, memory type
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  localparam logic [31:0] C0 = 32'h107; // Boundary check, atomics and downstream maintenance on, default shareability 01
  localparam logic [14:0] EXP_STALL = 15'h0500;

  iocf_client client (.clk(mclk), .rst(reset), .issue(issue), .req_in(rq), .ready(req_ready),
    .valid(valid), .req(req));
  iocf_filter dut (.MCLK(mclk), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .REQ_VALID(valid), .REQ(req), .STREAM_TABLE_ENTRY(s), .PERM(p),
    .REQ_READY(req_ready), .RESUME_VALID(resume_valid), .RESUME_RETRY(resume_retry),
    .FWD_VALID(fwd_valid), .FWD(fwd), .TERM_VALID(term_valid), .TERM_RESP(term_resp),
    .UUT_EVENT(uut_event), .FAULT_VALID(fault_valid), .FAULT_READ(fault_read),
    .FAULT_INSTR(fault_instr), .STALL(stall), .AF_UPDATE(af_update));

  ////////////////////////////////////////////////////////////////////////////
  // Expected outcome codes
  function automatic logic [14:0] fw(iocf_op_t op, logic [1:0] sh, logic af);
    return {7'h40, af, op, sh, 1'b0};
  endfunction

  function automatic logic [14:0] tm(logic [1:0] resp, logic uut, logic flt);
    return {2'b01, resp, 1'b0, uut, flt, 8'h00};
  endfunction

  // Single compare, counted
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t ns: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One AHB-Lite single word transfer; returns at the data-phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rv);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rv = hrdata;
    chk(32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    bus(1'b0, a, 32'h0, v);
  endtask

  // Catch the one outcome pulse mid-cycle; return on a rising edge
  task automatic wait_out();
    got = '0;
    for (int i = 0; i < 30; i++) begin
      @(negedge mclk);
      if ((fwd_valid | term_valid | stall) === 1'b1) begin
        got = {fwd_valid, term_valid, term_valid ? term_resp : 2'b00, stall, uut_event,
               fault_valid, af_update, fwd_valid ? {fwd.op, fwd.sh, fwd.has_mtype} : 7'h0};
        got_rdy = req_ready;
        break;
      end
    end
    @(posedge mclk);
  endtask

  // Offer one request through the client model and judge its outcome
  task automatic try(input iocf_op_t op, input logic [14:0] e);
    rq.op <= op;
    issue <= 1'b1;
    @(posedge mclk);
    issue <= 1'b0;
    wait_out();
    chk({17'h0, e}, {17'h0, got});
  endtask

  // Resolve a stalled request: retry or terminate
  task automatic resume(input logic retry, input logic [14:0] e);
    resume_valid <= 1'b1;
    resume_retry <= retry;
    @(posedge mclk);
    resume_valid <= 1'b0;
    wait_out();
    chk({17'h0, e}, {17'h0, got});
  endtask

  // Control word plus a translated, fully permitted default request
  task automatic setup(input logic [31:0] c);
    wr(IOCF_REG_CTRL, c);
    rq <= '{IOCF_OP_CLEAN, 48'h1000, 12'h03f, 1'b0, 1'b0, 1'b1, 2'b10};
    s <= '{IOCF_CFG_S1, 1'b0, 1'b0, 2'b00, 2'b00, 1'b0, 1'b0};
    p <= 8'hfe;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic s_regs();
    rd(IOCF_REG_CTRL, v0);
    chk(32'h7, v0);
    wr(IOCF_REG_STAT, 32'hffffffff); // Read-only: write must vanish
    rd(IOCF_REG_STAT, v0);
    chk(32'h0, v0);
    rd(8'h0c, v0);
    chk(32'h0, v0);
  endtask

  task automatic s_classes();
    iocf_op_t cl[3] = '{IOCF_OP_CLEAN, IOCF_OP_CLNINV, IOCF_OP_PERSIST};
    setup(C0);
    foreach (cl[i]) try(cl[i], fw(cl[i], 2'b10, 1'b0));
    try(IOCF_OP_INV, fw(IOCF_OP_CLNINV, 2'b10, 1'b0));
    s.invalidate_passthrough_enable <= 1'b1;
    try(IOCF_OP_INV, fw(IOCF_OP_INV, 2'b10, 1'b0));
    p <= 8'h00; // No permission: class must win over any fault
    try(IOCF_OP_VMMSG, tm(IOCF_RESP_SLVERR, 1'b0, 1'b0));
    try(IOCF_OP_BARRIER, tm(IOCF_RESP_SLVERR, 1'b0, 1'b0));
    try(IOCF_OP_CMONOAD, tm(IOCF_RESP_OKAY, 1'b0, 1'b0));
  endtask

  task automatic s_bypass();
    setup(C0);
    rq.sh_valid <= 1'b0;
    s.cfg <= IOCF_CFG_BYPASS;
    p <= 8'h00;
    try(IOCF_OP_INV, fw(IOCF_OP_INV, 2'b01, 1'b0));
    s.cfg <= IOCF_CFG_S1;
    s.substream_default_skip_skip <= 1'b1;
    try(IOCF_OP_INV, fw(IOCF_OP_INV, 2'b01, 1'b0));
    wr(IOCF_REG_CTRL, C0 | 32'h40);
    s.substream_default_skip_skip <= 1'b0;
    try(IOCF_OP_INV, fw(IOCF_OP_INV, 2'b01, 1'b0));
  endtask

  task automatic s_perm();
    setup(C0);
    s.invalidate_passthrough_enable <= 1'b1;
    p.w_user <= 1'b0;
    try(IOCF_OP_INV, fw(IOCF_OP_CLNINV, 2'b10, 1'b0));
    p <= 8'hee; // User read withdrawn
    try(IOCF_OP_INV, tm(IOCF_RESP_SLVERR, 1'b0, 1'b1));
    chk(32'h2, {30'h0, fault_read, fault_instr});
    rq.instr <= 1'b1;
    try(IOCF_OP_CLEAN, fw(IOCF_OP_CLEAN, 2'b10, 1'b0));
    s.instr_data_override <= IOCF_INST_DATA;
    try(IOCF_OP_CLEAN, tm(IOCF_RESP_SLVERR, 1'b0, 1'b1));
    chk(32'h2, {30'h0, fault_read, fault_instr});
    s.instr_data_override <= 2'b00;
    rq.instr <= 1'b0;
    p <= 8'he2; // Privileged permissions only
    try(IOCF_OP_CLEAN, tm(IOCF_RESP_SLVERR, 1'b0, 1'b1));
    s.privilege_override <= IOCF_PRIV_PRIV;
    try(IOCF_OP_CLEAN, fw(IOCF_OP_CLEAN, 2'b10, 1'b0));
  endtask

  task automatic s_limits();
    setup(C0 & ~32'h4);
    try(IOCF_OP_CLEAN, tm(IOCF_RESP_OKAY, 1'b0, 1'b0));
    try(IOCF_OP_READ, fw(IOCF_OP_READ, 2'b10, 1'b0) | 15'h1);
    wr(IOCF_REG_CTRL, C0 & ~32'h2);
    rd(IOCF_REG_STAT, v0);
    chk(32'h0004_0000, v0);
    try(IOCF_OP_ATOMIC, tm(IOCF_RESP_SLVERR, 1'b1, 1'b0));
    rd(IOCF_REG_STAT, v1);
    chk({16'h0, v0[15:0] + 16'h1}, {16'h0, v1[15:0]});
    wr(IOCF_REG_CTRL, C0);
    rq.addr <= 48'h1fc0; // Ends on the last byte of the page
    try(IOCF_OP_CLEAN, fw(IOCF_OP_CLEAN, 2'b10, 1'b0));
    chk(32'h1fc0, fwd.addr[31:0]);
    rq.addr <= 48'h1fc1;
    try(IOCF_OP_CLEAN, tm(IOCF_RESP_SLVERR, 1'b1, 1'b0));
  endtask

  task automatic s_sif();
    setup(C0 | 32'h20);
    s.secure <= 1'b1;
    s.cfg <= IOCF_CFG_BYPASS;
    rq.instr <= 1'b1;
    p.out_ns <= 1'b1;
    try(IOCF_OP_CLEAN, tm(IOCF_RESP_SLVERR, 1'b0, 1'b1));
    chk(32'h3, {30'h0, fault_read, fault_instr});
    rd(IOCF_REG_FLT, v0);
    chk(32'h15, v0);
    s.cfg <= IOCF_CFG_S1;
    try(IOCF_OP_CLEAN, tm(IOCF_RESP_SLVERR, 1'b0, 1'b1));
    p.out_ns <= 1'b0;
    try(IOCF_OP_CLEAN, fw(IOCF_OP_CLEAN, 2'b10, 1'b0));
  endtask

  task automatic s_stall();
    setup(C0 | 32'h8);
    s.invalidate_passthrough_enable <= 1'b1;
    p <= 8'hee;
    try(IOCF_OP_INV, EXP_STALL);
    chk(32'h0, {31'h0, got_rdy});
    p <= 8'hfe; // Permission granted for the retry
    resume(1'b1, fw(IOCF_OP_INV, 2'b10, 1'b0));
    p <= 8'hee;
    try(IOCF_OP_CLEAN, EXP_STALL);
    resume(1'b0, tm(IOCF_RESP_SLVERR, 1'b0, 1'b0));
  endtask

  task automatic s_af();
    setup(C0 | 32'h10);
    p.desc_af <= 1'b0;
    try(IOCF_OP_CLEAN, fw(IOCF_OP_CLEAN, 2'b10, 1'b1));
    s.invalidate_passthrough_enable <= 1'b1;
    try(IOCF_OP_INV, fw(IOCF_OP_INV, 2'b10, 1'b1));
    s.access_fault_disable <= 1'b1;
    try(IOCF_OP_CLEAN, fw(IOCF_OP_CLEAN, 2'b10, 1'b0));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock, hang guard and main sequence
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Whole run is about 150 cycles; this only cuts a hang short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    issue = 1'b0;
    resume_valid = 1'b0;
    resume_retry = 1'b0;
    rq = '0;
    s = '0;
    p = '0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    s_regs();
    s_classes();
    s_bypass();
    s_perm();
    s_limits();
    s_sif();
    s_stall();
    s_af();
    tally_and_finish();
  end
endmodule
